// File: src/sac_pkg.sv
/*
 * Shared constants for the converter timing and multiplexer control block.
 * Assumes a single 20 MHz system clock and an APB register bus.
 */
package sac_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ACQ_PAIR_A = 8'h04;
  localparam logic [7:0] ADDR_ACQ_PAIR_B = 8'h08;
  localparam logic [7:0] ADDR_SEQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_FW_SWITCH = 8'h10;
  localparam logic [7:0] ADDR_CHAN_EN = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_CHAN_BASE = 8'h40;
  // ==========================================================
  // Control register fields
  localparam int CTRL_REF_LSB = 4;
  localparam int CTRL_BYPASS_BIT = 7;
  localparam int CTRL_NEG_LSB = 9;
  localparam int CTRL_ALT_RES_BIT = 12;
  localparam int CTRL_START_BIT = 13;
  localparam int CTRL_CONT_BIT = 14;
  localparam int CTRL_DIV_LSB = 16;
  localparam int TEMP_ROUTE_BIT = 17;
  localparam logic [31:0] CTRL_RESET = 32'h0002_0070;
  // ==========================================================
  // Reference codes
  localparam logic [2:0] REF_BANDGAP = 3'h4;
  localparam logic [2:0] REF_EXTERNAL = 3'h5;
  localparam logic [2:0] REF_HALF_VDDA = 3'h6;
  localparam logic [2:0] REF_VDDA = 3'h7;
  // ==========================================================
  // Timing
  localparam logic [9:0] ACQ_MIN = 10'h004;
  localparam logic [9:0] ACQ_RESET = 10'h004;
  localparam logic [4:0] RES_FULL = 5'h0C;
  localparam logic [4:0] RES_ALT_8 = 5'h08;
  localparam logic [4:0] RES_ALT_10 = 5'h0A;
  localparam logic [4:0] FINAL_STATES = 5'h02;
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int CONV_CLK_MAX_HZ = 18_000_000;
  localparam int CONV_CLK_MIN_HZ = 1_000_000;
  localparam int MIN_SETTLE_NS = 194;
  localparam logic [7:0] DIV_MIN = 8'(1 + (SYS_CLK_HZ - 1) / CONV_CLK_MAX_HZ);
  localparam logic [7:0] DIV_MAX = 8'(SYS_CLK_HZ / CONV_CLK_MIN_HZ);
  localparam int NUM_CHAN = 16;
  localparam int NUM_PINS = 8;
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_ACQ = 2'b01,
    SAC_CONV = 2'b11
  } sac_state_t;
endpackage

// File: src/sac_cfg_if.sv
/*
 * Channel setup memory port bundle.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ns
`default_nettype none
interface sac_cfg_if;
  logic we;
  logic [3:0] waddr;
  logic [15:0] wdata;
  logic [3:0] raddr;
  logic [15:0] rdata;
  modport owner (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// File: src/sac_chan_mem.sv
/*
 * Per-channel setup store, registered read data.
 * Assumes the owner drives the port synchronously.
 */
`timescale 1ns/1ns
`default_nettype none
module sac_chan_mem #(
  parameter int DEPTH = 16
) (
  input wire logic i_sys_clk,
  sac_cfg_if.mem port
);
  logic [15:0] store [DEPTH];
  always_ff @(posedge i_sys_clk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    port.rdata <= store[port.raddr];
  end
endmodule // sac_chan_mem
`default_nettype wire

// File: src/sac_ctrl.sv
/*
 * Converter timing and input multiplexer control with APB registers.
 * Assumes 20 MHz system clock, asynchronous active-low reset,
 * and an analog core that samples on the emitted control levels.
 */
// What this block does
// RULE1: 12-bit default, per-channel global 8/10 alternate
// RULE2: Conversion lasts resolution plus two cycles
// RULE3: Sample total is acquisition plus resolution plus two
// RULE4: Minimum acquisition gives 18, 16 or 14 cycles
// RULE5: Input disconnected when acquisition ends
// RULE6: Four global acquisition settings, 4 to 1023
// RULE7: Converter clock by integer divider, 1-18 MHz
// RULE8: Acquisition never below 4 cycles
// RULE9: Pulse when sampling ends, sequencer reroutes
// RULE10: Per-switch mask gives sequencer control
// RULE11: Sequencer scans enabled channels round-robin
// RULE12: Firmware sets every switch directly; code applies it only where the sequencer mask bit is 0
// RULE13: Sequencer pairs only adjacent even/odd pins
// RULE14: Temperature routing bit enables sensor bias
// RULE15: Software uses sensor single-ended only
// RULE16: Control bits 6:4 select the reference
// RULE17: Reference codes 4-7, separate bypass bit
// RULE18: Sensor selected forces negative selection zero
// RULE19: Cycle counter loads acquisition then counts conversion
`timescale 1ns/1ns
`default_nettype none
module sac_ctrl #(
  parameter int NCHAN = sac_pkg::NUM_CHAN
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_conv_clk,
  output logic o_sample_hold,
  output logic o_sample_done,
  output logic o_result_valid,
  output logic [4:0] o_resolution,
  output logic [31:0] o_switch,
  output logic [2:0] o_neg_sel,
  output logic o_temp_bias_en,
  output logic [3:0] o_ref_onehot,
  output logic o_bypass_en,
  output logic [3:0] o_chan
);
  if (NCHAN != 16) begin : g_nchan_check
    $error("sac_ctrl supports exactly 16 channels");
  end
  // ==========================================================
  // Registers
  logic [31:0] ctrl;
  logic [31:0] acq_time_setting_pair_a;
  logic [31:0] acq_time_setting_pair_b;
  logic [31:0] switch_sequencer_mask;
  logic [31:0] firmware_switch_settings;
  logic [15:0] chan_en;
  logic start_clear;
  sac_cfg_if cfg ();
  sac_chan_mem #(.DEPTH(NCHAN)) u_mem (.i_sys_clk(i_sys_clk), .port(cfg.mem));
  // ==========================================================
  // APB decode
  wire acc = i_psel && i_penable;
  wire wr = acc && i_pwrite;
  wire is_chan = (i_paddr[7:6] == sac_pkg::ADDR_CHAN_BASE[7:6]) && (i_paddr[1:0] == 2'h0);
  wire is_ctrl = i_paddr == sac_pkg::ADDR_CTRL;
  wire is_pa = i_paddr == sac_pkg::ADDR_ACQ_PAIR_A;
  wire is_pb = i_paddr == sac_pkg::ADDR_ACQ_PAIR_B;
  wire is_mask = i_paddr == sac_pkg::ADDR_SEQ_MASK;
  wire is_fw = i_paddr == sac_pkg::ADDR_FW_SWITCH;
  wire is_en = i_paddr == sac_pkg::ADDR_CHAN_EN;
  wire is_st = i_paddr == sac_pkg::ADDR_STATUS;
  wire mapped = is_chan || is_ctrl || is_pa || is_pb || is_mask || is_fw || is_en || is_st;
  // Channel reads take one extra wait state for the registered memory
  logic chan_wait;
  wire next_ready = acc && !o_pready && (!is_chan || i_pwrite || chan_wait);
  // Clamp acquisition values below the minimum
  function automatic logic [9:0] clamp_acq(input logic [9:0] v);
    clamp_acq = (v < sac_pkg::ACQ_MIN) ? sac_pkg::ACQ_MIN : v; // RULE8
  endfunction
  function automatic logic [31:0] pair_word(input logic [31:0] d);
    pair_word = {6'h00, clamp_acq(d[25:16]), 6'h00, clamp_acq(d[9:0])}; // RULE6
  endfunction
  // Divider clamped to 1..18 MHz range
  wire [7:0] div_raw = i_pwdata[sac_pkg::CTRL_DIV_LSB +: 8];
  wire [7:0] div_ok = (div_raw < sac_pkg::DIV_MIN) ? sac_pkg::DIV_MIN :
                      (div_raw > sac_pkg::DIV_MAX) ? sac_pkg::DIV_MAX : div_raw; // RULE7
  wire [31:0] ctrl_wdata = {8'h00, div_ok, i_pwdata[15:0]};
  assign cfg.we = wr && next_ready && is_chan;
  assign cfg.waddr = i_paddr[5:2];
  assign cfg.wdata = i_pwdata[15:0];
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= sac_pkg::CTRL_RESET;
      acq_time_setting_pair_a <= {6'h00, sac_pkg::ACQ_RESET, 6'h00, sac_pkg::ACQ_RESET};
      acq_time_setting_pair_b <= {6'h00, sac_pkg::ACQ_RESET, 6'h00, sac_pkg::ACQ_RESET};
      switch_sequencer_mask <= 32'h0000_0000;
      firmware_switch_settings <= 32'h0000_0000;
      chan_en <= 16'h0000;
    end else begin
      // Scan-end clear first, so a software write in the same cycle wins
      if (start_clear) begin
        ctrl[sac_pkg::CTRL_START_BIT] <= 1'b0;
      end
      if (wr && next_ready) begin
        if (is_ctrl) ctrl <= ctrl_wdata;
        if (is_pa) acq_time_setting_pair_a <= pair_word(i_pwdata);
        if (is_pb) acq_time_setting_pair_b <= pair_word(i_pwdata);
        if (is_mask) switch_sequencer_mask <= i_pwdata;
        if (is_fw) firmware_switch_settings <= i_pwdata;
        if (is_en) chan_en <= i_pwdata[15:0];
      end
    end
  end
  // ==========================================================
  // Converter clock divider
  logic [7:0] div_cnt;
  wire [7:0] div_val = ctrl[sac_pkg::CTRL_DIV_LSB +: 8];
  wire div_wrap = div_cnt >= div_val - 8'h01;
  wire conv_tick = div_wrap;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_cnt <= 8'h00;
      o_conv_clk <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? 8'h00 : div_cnt + 8'h01; // RULE7
      o_conv_clk <= div_cnt < {1'b0, div_val[7:1]};
    end
  end
  // ==========================================================
  // Sequencer and cycle counter
  sac_pkg::sac_state_t state;
  sac_pkg::sac_state_t next_state;
  logic [9:0] cnt;
  logic [3:0] chan;
  logic [3:0] next_chan;
  // Setup read port shared with APB reads; sequencer keeps a copy meanwhile
  logic stolen;
  logic [15:0] seq_cfg;
  wire steal = acc && is_chan && !i_pwrite;
  wire [15:0] cur_cfg = stolen ? seq_cfg : cfg.rdata;
  function automatic logic [9:0] acquisition(input logic [31:0] p, input logic hi);
    acquisition = hi ? p[25:16] : p[9:0];
  endfunction
  // Channel setup: [2:0] pos pin, [3] diff, [5:4] acq select, [6] alt res, [7] temp
  wire [9:0] acq_sel =
    (cur_cfg[5:4] == 2'h0) ? acquisition(acq_time_setting_pair_a, 1'b0) :
    (cur_cfg[5:4] == 2'h1) ? acquisition(acq_time_setting_pair_a, 1'b1) :
    (cur_cfg[5:4] == 2'h2) ? acquisition(acq_time_setting_pair_b, 1'b0) :
                             acquisition(acq_time_setting_pair_b, 1'b1); // RULE6
  wire [4:0] alt_res = ctrl[sac_pkg::CTRL_ALT_RES_BIT] ? sac_pkg::RES_ALT_10 : sac_pkg::RES_ALT_8;
  wire [4:0] res = cur_cfg[6] ? alt_res : sac_pkg::RES_FULL; // RULE1
  wire [9:0] conv_len = {5'h00, res + sac_pkg::FINAL_STATES}; // RULE2
  wire go = ctrl[sac_pkg::CTRL_START_BIT] || ctrl[sac_pkg::CTRL_CONT_BIT];
  wire any_en = |chan_en;
  // Round-robin search for the next enabled channel
  always_comb begin
    next_chan = chan;
    for (int k = NCHAN - 1; k >= 1; k--) begin
      if (chan_en[4'(chan + 4'(k))]) begin
        next_chan = 4'(chan + 4'(k)); // RULE11
      end
    end
    if (!chan_en[next_chan] && chan_en[chan]) begin
      next_chan = chan;
    end
  end
  wire cnt_last = cnt == 10'h001;
  // Scan has wrapped when the upcoming channel is not above the current one
  wire scan_wrap = chan <= o_chan;
  wire keep_going = (ctrl[sac_pkg::CTRL_CONT_BIT] || (ctrl[sac_pkg::CTRL_START_BIT] && !scan_wrap)) && chan_en[chan];
  always_comb begin
    next_state = state;
    unique case (state)
      sac_pkg::SAC_IDLE: if (conv_tick && go && any_en && chan_en[chan] && !stolen) next_state = sac_pkg::SAC_ACQ;
      sac_pkg::SAC_ACQ: if (conv_tick && cnt_last) next_state = sac_pkg::SAC_CONV; // RULE19
      // Back-to-back samples with no idle tick between them
      sac_pkg::SAC_CONV: if (conv_tick && cnt_last) next_state = keep_going ? sac_pkg::SAC_ACQ : sac_pkg::SAC_IDLE; // RULE3
    endcase
  end
  assign cfg.raddr = steal ? i_paddr[5:2] : chan;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= sac_pkg::SAC_IDLE;
      cnt <= 10'h000;
      chan <= 4'h0;
      start_clear <= 1'b0;
      stolen <= 1'b0;
      seq_cfg <= 16'h0000;
      o_sample_done <= 1'b0;
      o_result_valid <= 1'b0;
      o_sample_hold <= 1'b0;
      o_resolution <= sac_pkg::RES_FULL;
      o_chan <= 4'h0;
    end else begin
      state <= next_state;
      start_clear <= 1'b0;
      stolen <= steal;
      o_sample_done <= 1'b0;
      o_result_valid <= 1'b0;
      if (!stolen) begin
        seq_cfg <= cfg.rdata;
      end
      if (state == sac_pkg::SAC_IDLE && conv_tick && !chan_en[chan] && any_en) begin
        chan <= next_chan;
      end
      if (state == sac_pkg::SAC_CONV && next_state != sac_pkg::SAC_CONV) begin
        o_result_valid <= 1'b1; // RULE19
        start_clear <= scan_wrap;
      end
      if (state != sac_pkg::SAC_ACQ && next_state == sac_pkg::SAC_ACQ) begin
        cnt <= clamp_acq(acq_sel); // RULE19 RULE8
        o_resolution <= res;
        o_chan <= chan;
        o_sample_hold <= 1'b0;
      end else if (state == sac_pkg::SAC_ACQ && next_state == sac_pkg::SAC_CONV) begin
        cnt <= conv_len; // RULE2 RULE4
        o_sample_hold <= 1'b1; // RULE5
        o_sample_done <= 1'b1; // RULE9
        chan <= next_chan; // RULE9
      end else if (next_state == sac_pkg::SAC_IDLE) begin
        o_sample_hold <= 1'b0;
      end else if (conv_tick && state != sac_pkg::SAC_IDLE) begin
        cnt <= cnt - 10'h001;
      end
    end
  end
  // ==========================================================
  // Switch routing
  logic [31:0] seq_switch;
  wire [2:0] pos_pin = cur_cfg[3] ? {cur_cfg[2:1], 1'b0} : cur_cfg[2:0]; // RULE13
  wire [2:0] neg_pin = {cur_cfg[2:1], 1'b1}; // RULE13
  wire seq_active = state != sac_pkg::SAC_IDLE;
  always_comb begin
    seq_switch = 32'h0000_0000;
    if (seq_active) begin
      if (cur_cfg[7]) begin
        seq_switch[sac_pkg::TEMP_ROUTE_BIT] = 1'b1;
      end else begin
        seq_switch[pos_pin] = 1'b1;
        if (cur_cfg[3]) begin
          seq_switch[sac_pkg::NUM_PINS + 32'(neg_pin)] = 1'b1;
        end
      end
    end
  end
  // Mask picks sequencer per switch, others stay firmware
  wire [31:0] next_switch = (switch_sequencer_mask & seq_switch) |
                            (~switch_sequencer_mask & firmware_switch_settings); // RULE10 RULE12
  wire temp_on = next_switch[sac_pkg::TEMP_ROUTE_BIT];
  wire [2:0] ref_sel = ctrl[sac_pkg::CTRL_REF_LSB +: 3];
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_switch <= 32'h0000_0000;
      o_temp_bias_en <= 1'b0;
      o_neg_sel <= 3'h0;
      o_ref_onehot <= 4'h0;
      o_bypass_en <= 1'b0;
    end else begin
      o_switch <= next_switch; // RULE12
      o_temp_bias_en <= temp_on; // RULE14
      o_neg_sel <= temp_on ? 3'h0 : ctrl[sac_pkg::CTRL_NEG_LSB +: 3]; // RULE18
      o_ref_onehot <= {ref_sel == sac_pkg::REF_VDDA, ref_sel == sac_pkg::REF_HALF_VDDA,
                       ref_sel == sac_pkg::REF_EXTERNAL, ref_sel == sac_pkg::REF_BANDGAP}; // RULE16 RULE17
      o_bypass_en <= ctrl[sac_pkg::CTRL_BYPASS_BIT]; // RULE17
    end
  end
  // ==========================================================
  // APB read path
  wire [31:0] status = {22'h0, o_sample_hold, state == sac_pkg::SAC_ACQ, 4'(chan), 4'(o_resolution)};
  wire [31:0] rd_mux = is_ctrl ? ctrl : is_pa ? acq_time_setting_pair_a :
                       is_pb ? acq_time_setting_pair_b : is_mask ? switch_sequencer_mask :
                       is_fw ? firmware_switch_settings : is_en ? {16'h0, chan_en} :
                       is_st ? status : is_chan ? {16'h0, cfg.rdata} : 32'h0;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      chan_wait <= 1'b0;
    end else begin
      o_pready <= next_ready;
      o_pslverr <= next_ready && !mapped;
      chan_wait <= acc && is_chan && !o_pready && !chan_wait;
      if (next_ready && !i_pwrite) begin
        o_prdata <= rd_mux;
      end
    end
  end
endmodule // sac_ctrl
`default_nettype wire

// File: verification/sac_ctrl_chk.sv
/*
 * Port checker for sac_ctrl.
 * Assumes binding to every sac_ctrl instance, one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
module sac_ctrl_chk (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_sample_hold,
  input wire logic o_sample_done,
  input wire logic o_result_valid,
  input wire logic [4:0] o_resolution,
  input wire logic [31:0] o_switch,
  input wire logic [2:0] o_neg_sel,
  input wire logic o_temp_bias_en,
  input wire logic [3:0] o_ref_onehot
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // ==========================================================
  // Bus answers
  err_with_ready_a: assert property (o_pslverr |-> o_pready) else $error("pslverr without pready");
  ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("pready longer than one cycle");
  ready_after_access_a: assert property (o_pready |-> $past(i_psel && i_penable)) else $error("pready without access");
  // ==========================================================
  // Converter timing and routing
  res_legal_a: assert property (o_resolution inside {5'h08, 5'h0A, 5'h0C}) else $error("bad resolution");
  done_pulse_a: assert property (o_sample_done |=> !o_sample_done) else $error("done not a pulse");
  hold_after_done_a: assert property (o_sample_done |-> ##[0:2] o_sample_hold) else $error("input not held");
  hold_min_a: assert property ($rose(o_sample_hold) |-> o_sample_hold [*8]) else $error("hold too short");
  valid_pulse_a: assert property (o_result_valid |=> !o_result_valid) else $error("valid not a pulse");
  temp_bias_a: assert property (o_temp_bias_en == o_switch[17]) else $error("bias differs from route");
  temp_neg_zero_a: assert property (o_switch[17] |-> o_neg_sel == 3'h0) else $error("neg not forced");
  ref_onehot_a: assert property ($onehot0(o_ref_onehot)) else $error("reference not one-hot");
endmodule // sac_ctrl_chk
bind sac_ctrl sac_ctrl_chk chk_u (.i_sys_clk, .i_arst_n, .i_psel, .i_penable, .o_pready, .o_pslverr,
  .o_sample_hold, .o_sample_done, .o_result_valid, .o_resolution, .o_switch, .o_neg_sel,
  .o_temp_bias_en, .o_ref_onehot);
`default_nettype wire

// File: verification/sac_core_model.sv
/*
 * Converter core model: counts converter clock ticks per sample.
 * Assumes the converter clock is a level sampled on the system clock.
 */
`timescale 1ns/1ns
`default_nettype none
module sac_core_model (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_conv_clk,
  input wire logic i_hold,
  input wire logic i_valid,
  output logic [9:0] o_conv_n,
  output logic [11:0] o_period_n,
  output logic [15:0] o_samples
);
  logic prev_clk;
  logic [9:0] cnt_c;
  logic [11:0] cnt_p;
  wire tick = i_conv_clk & !prev_clk;
  // ==========================================================
  // Tick counting per sample
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_clk <= 1'b0;
      cnt_c <= 10'h000;
      cnt_p <= 12'h000;
      o_conv_n <= 10'h000;
      o_period_n <= 12'h000;
      o_samples <= 16'h0000;
    end else begin
      prev_clk <= i_conv_clk;
      if (i_valid) begin
        o_conv_n <= cnt_c;
        o_period_n <= cnt_p;
        o_samples <= o_samples + 16'h0001;
        cnt_c <= 10'h000;
        cnt_p <= {11'h000, tick};
      end else begin
        cnt_c <= cnt_c + 10'(tick & i_hold);
        cnt_p <= cnt_p + 12'(tick);
      end
    end
  end
endmodule // sac_core_model
`default_nettype wire

// File: verification/sac_ctrl_bench.sv
/*
 * Self-checking bench for sac_ctrl over APB.
 * Assumes the checker is bound and the core model watches the outputs.
 */
`timescale 1ns/1ns
`default_nettype none
module sac_ctrl_bench;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  wire [31:0] o_prdata, o_switch;
  wire o_pready, o_pslverr, o_conv_clk, o_sample_hold, o_sample_done, o_result_valid, o_temp_bias_en, o_bypass_en;
  wire [4:0] o_resolution;
  wire [2:0] o_neg_sel;
  wire [3:0] o_ref_onehot, o_chan;
  wire [9:0] cn;
  wire [11:0] pn;
  wire [15:0] ns;
  logic [31:0] r = 32'hCF30_5CE8;
  logic [31:0] rd, v;
  logic [9:0] a, acq;
  logic [4:0] rs;
  logic [3:0] c0;
  logic er, alt, ten;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  always #25 i_sys_clk = ~i_sys_clk;
  sac_ctrl dut_u (.*);
  sac_core_model core_u (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_conv_clk(o_conv_clk),
    .i_hold(o_sample_hold), .i_valid(o_result_valid), .o_conv_n(cn), .o_period_n(pn), .o_samples(ns));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] ref_exp(input logic [2:0] c);
    return c[2] ? 4'h1 << c[1:0] : 4'h0;
  endfunction
  function automatic logic [4:0] res_exp(input logic al, input logic tn);
    return !al ? 5'h0C : (tn ? 5'h0A : 5'h08);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic samples(input int n);
    int s;
    s = ns;
    while (ns < s + n) @(posedge i_sys_clk);
  endtask
  task automatic next_valid();
    do @(posedge i_sys_clk); while (o_result_valid !== 1'b1);
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      final_report();
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    apb(0, sac_pkg::ADDR_CTRL, 0);
    chk(rd, sac_pkg::CTRL_RESET);
    apb(1, 8'h20, 32'hFFFF_FFFF);
    apb(0, 8'h20, 0);
    chk({rd[30:0], er}, 32'h1);
    for (int c = 0; c < 8; c++) begin
      r = lfsr(r);
      apb(1, sac_pkg::ADDR_CTRL, {16'h0002, 8'h00, r[7], 3'(c), 4'h0});
      repeat (2) @(posedge i_sys_clk);
      chk(32'(o_ref_onehot), 32'(ref_exp(3'(c))));
      chk(32'(o_bypass_en), 32'(r[7]));
    end
    apb(1, sac_pkg::ADDR_ACQ_PAIR_B, {6'h0, 10'h3FF, 6'h0, 10'h002});
    apb(0, sac_pkg::ADDR_ACQ_PAIR_B, 0);
    chk(rd, 32'h03FF_0004);
    r = lfsr(r);
    a = 10'(r[6:0]) + 10'h004;
    apb(1, sac_pkg::ADDR_ACQ_PAIR_A, {6'h0, a, 16'h0004});
    apb(0, sac_pkg::ADDR_ACQ_PAIR_A, 0);
    chk(rd, {6'h0, a, 16'h0004});
    apb(1, sac_pkg::ADDR_SEQ_MASK, 0);
    r = lfsr(r);
    v = (r & 32'h0000_FFFF) | 32'h0002_0000;
    apb(1, sac_pkg::ADDR_FW_SWITCH, v);
    apb(1, sac_pkg::ADDR_CTRL, 32'h0002_0E70);
    repeat (2) @(posedge i_sys_clk);
    chk(o_switch, v);
    chk(32'(o_temp_bias_en), 32'h1);
    chk(32'(o_neg_sel), 32'h0);
    apb(1, sac_pkg::ADDR_FW_SWITCH, v & 32'h0000_FFFF);
    repeat (2) @(posedge i_sys_clk);
    chk(32'(o_temp_bias_en), 32'h0);
    chk(32'(o_neg_sel), 32'h7);
    // Sequencer: pins 2/3 differential, 12/8/10-bit resolutions, two acquisition settings
    apb(1, sac_pkg::ADDR_FW_SWITCH, 0);
    apb(1, sac_pkg::ADDR_SEQ_MASK, 32'hFFFF_FFFF);
    apb(1, sac_pkg::ADDR_CHAN_EN, 1);
    for (int m = 0; m < 4; m++) begin
      alt = (m == 1 || m == 2);
      ten = (m == 2);
      rs = res_exp(alt, ten);
      acq = (m == 3) ? a : 10'h004;
      apb(1, sac_pkg::ADDR_CHAN_BASE, {24'h0, 1'b0, alt, 2'(m == 3), 4'hB});
      apb(1, sac_pkg::ADDR_CTRL, {16'h0002, 1'b0, 1'b1, 1'b0, ten, 12'h070});
      samples(3);
      chk(32'(cn), 32'(rs) + 2);
      chk(32'(pn), 32'(acq) + 32'(rs) + 2);
      chk(32'(o_resolution), 32'(rs));
      chk(32'(o_switch[15:0]), 32'h0804);
    end
    apb(1, sac_pkg::ADDR_CHAN_BASE + 8'h04, 0);
    apb(1, sac_pkg::ADDR_CHAN_BASE + 8'h08, 5);
    apb(1, sac_pkg::ADDR_CHAN_EN, 32'h6);
    apb(0, sac_pkg::ADDR_CHAN_BASE + 8'h08, 0);
    chk(rd, 32'h5);
    samples(2);
    next_valid();
    c0 = o_chan;
    next_valid();
    chk(32'(o_chan), 32'(c0 ^ 4'h3));
    next_valid();
    chk(32'(o_chan), 32'(c0));
    // One scan only: start bit clears at the wrap and sampling stops
    apb(1, sac_pkg::ADDR_CTRL, 32'h0002_2070);
    repeat (400) @(posedge i_sys_clk);
    apb(0, sac_pkg::ADDR_CTRL, 0);
    chk(rd, 32'h0002_0070);
    v = 32'(ns);
    repeat (200) @(posedge i_sys_clk);
    chk(32'(ns), v);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    apb(0, sac_pkg::ADDR_CTRL, 0);
    chk(rd, sac_pkg::CTRL_RESET);
    final_report();
  end
endmodule // sac_ctrl_bench
`default_nettype wire
